// file: logic/spfc_top.sv
// Serial port of a receipt printer with hardware or in-band flow control.
//
// Summary of operation
// - Flow mode, word, baud, parity come from switches.
// - Hardware mode: host-ready mark withholds transmission.
// - Software mode: host-ready never withholds transmission; status still shows it.
// - Hardware mode: busy output mark when busy.
// - Software mode: send stop character 13h on busy.
// - Software mode: send resume 11h when busy clears.
// - Rates 2400, 4800, 9600, 19200 bits per second.
// - Seven or eight data bits, none/even/odd parity.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module spfc_top
	import spfc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic swFlowSoft,
	input wire logic [1:0] swBaud,
	input wire logic swWord8,
	input wire logic [1:0] swParity,
	input wire logic rxLine,
	input wire logic hostReady,
	output logic txLine,
	output logic printerBusy,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData
);

	typedef struct packed {
		spfc_tx_t txState;
		spfc_rx_t rxState;
		logic [9:0] divCnt;
		logic [3:0] txSub;
		logic [3:0] txBit;
		logic [7:0] txShift;
		logic txPar;
		logic txLine;
		logic [3:0] rxSub;
		logic [3:0] rxBit;
		logic [7:0] rxShift;
		logic rxPar;
		logic [7:0] holdData;
		logic holdFull;
		logic xoffPend;
		logic xonPend;
		logic busyPrev;
		logic busyOut;
		logic parErr;
		logic frmErr;
		logic ovrErr;
		logic forceBusy;
		logic cfgSoft;
		logic [1:0] cfgBaud;
		logic cfgWord8;
		logic [1:0] cfgPar;
		logic [7:0] rdData;
	} spfc_st_t;

	spfc_st_t s_r;
	spfc_st_t s_nxt;

	logic tick;
	logic [9:0] divSel;
	logic [3:0] lastBit;
	logic parOn;
	logic busyNow;
	logic pushNow;
	logic [7:0] pushData;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	logic [7:0] fifoOutData;
	logic [3:0] fifoCount;
	logic bothIdle;

	////////////////////////////////////////////////////////////////////////
	// Received characters wait here until software reads them.
	spfc_fifo #(
		.WIDTH(8),
		.DEPTH(RX_DEPTH)
	) rxBuf (
		.clock(clock),
		.rst(rst),
		.inValid(pushNow),
		.inReady(fifoInReady),
		.inData(pushData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData),
		.count(fifoCount)
	);

	////////////////////////////////////////////////////////////////////////
	// Rate and frame shape follow the latched switch copy.
	always_comb
	begin
		unique case (s_r.cfgBaud)
			BAUD_SEL_2400: divSel = DIV_2400;
			BAUD_SEL_4800: divSel = DIV_4800;
			BAUD_SEL_9600: divSel = DIV_9600;
			default: divSel = DIV_19200;
		endcase
	end

	// Compare with at or above, so a rate switch to a shorter divisor
	// cannot leave the counter stranded past its end.
	assign tick = (s_r.divCnt >= divSel - 10'h001);
	assign lastBit = s_r.cfgWord8 ? 4'h7 : 4'h6;
	assign parOn = (s_r.cfgPar == PAR_EVEN) || (s_r.cfgPar == PAR_ODD);
	assign bothIdle = (s_r.txState == TX_IDLE) && (s_r.rxState == RX_IDLE);

	// The port is busy when the buffer nears full or software holds it.
	assign busyNow = s_r.forceBusy || (fifoCount >= BUSY_LEVEL);
	assign fifoPop = regRdStrobe && (regAddr == REG_RXDATA) && fifoOutValid;

	assign txLine = s_r.txLine;
	assign printerBusy = s_r.busyOut;
	assign regRdData = s_r.rdData;

	////////////////////////////////////////////////////////////////////////
	// Next state of the whole port.
	always_comb
	begin
		s_nxt = s_r;
		pushNow = 1'b0;
		pushData = 8'h00;

		// Switches are only taken between frames, so no frame is split.
		if (bothIdle)
		begin
			s_nxt.cfgSoft = swFlowSoft;
			s_nxt.cfgBaud = swBaud;
			s_nxt.cfgWord8 = swWord8;
			s_nxt.cfgPar = swParity;
		end

		// Baud divider producing the sixteen-times sample enable.
		s_nxt.divCnt = tick ? 10'h000 : s_r.divCnt + 10'h001;

		// Busy edges queue a flow character; the later edge wins.
		s_nxt.busyPrev = busyNow;
		if (s_r.cfgSoft && busyNow && !s_r.busyPrev)
		begin
			s_nxt.xoffPend = 1'b1;
			s_nxt.xonPend = 1'b0;
		end
		else if (s_r.cfgSoft && !busyNow && s_r.busyPrev)
		begin
			s_nxt.xonPend = 1'b1;
			s_nxt.xoffPend = 1'b0;
		end
		// In software mode the busy line rests at space.
		s_nxt.busyOut = !s_r.cfgSoft && busyNow;

		// Transmitter.
		unique case (s_r.txState)
			TX_IDLE:
			begin
				s_nxt.txSub = 4'h0;
				s_nxt.txBit = 4'h0;
				if (s_r.cfgSoft && (s_r.xoffPend || s_r.xonPend))
				begin
					s_nxt.txShift = s_r.xoffPend ? CHAR_XOFF : CHAR_XON;
					s_nxt.xoffPend = 1'b0;
					s_nxt.xonPend = 1'b0;
					s_nxt.txState = TX_START;
				end
				else if (s_r.holdFull && (s_r.cfgSoft || !hostReady))
				begin
					s_nxt.txShift = s_r.holdData;
					s_nxt.holdFull = 1'b0;
					s_nxt.txState = TX_START;
				end
				s_nxt.txPar = (s_r.cfgPar == PAR_ODD);
			end
			TX_START:
			begin
				if (tick)
				begin
					s_nxt.txSub = s_r.txSub + 4'h1;
					if (s_r.txSub == SUB_LAST)
					begin
						s_nxt.txState = TX_DATA;
					end
				end
			end
			TX_DATA:
			begin
				if (tick)
				begin
					s_nxt.txSub = s_r.txSub + 4'h1;
					if (s_r.txSub == SUB_LAST)
					begin
						// Least significant bit goes first.
						s_nxt.txPar = s_r.txPar ^ s_r.txShift[0];
						s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
						s_nxt.txBit = s_r.txBit + 4'h1;
						if (s_r.txBit == lastBit)
						begin
							s_nxt.txState = parOn ? TX_PAR : TX_STOP;
						end
					end
				end
			end
			TX_PAR:
			begin
				if (tick)
				begin
					s_nxt.txSub = s_r.txSub + 4'h1;
					if (s_r.txSub == SUB_LAST)
					begin
						s_nxt.txState = TX_STOP;
					end
				end
			end
			TX_STOP:
			begin
				if (tick)
				begin
					s_nxt.txSub = s_r.txSub + 4'h1;
					if (s_r.txSub == SUB_LAST)
					begin
						s_nxt.txState = TX_IDLE;
					end
				end
			end
		endcase

		// Line level follows the state being entered; rest is mark.
		unique case (s_nxt.txState)
			TX_START: s_nxt.txLine = 1'b0;
			TX_DATA: s_nxt.txLine = s_nxt.txShift[0];
			TX_PAR: s_nxt.txLine = s_nxt.txPar;
			default: s_nxt.txLine = 1'b1;
		endcase

		// Receiver; sixteen samples per bit, judged at mid-bit.
		unique case (s_r.rxState)
			RX_IDLE:
			begin
				s_nxt.rxSub = 4'h0;
				s_nxt.rxBit = 4'h0;
				s_nxt.rxPar = (s_r.cfgPar == PAR_ODD);
				if (!rxLine)
				begin
					s_nxt.rxState = RX_START;
				end
			end
			RX_START:
			begin
				if (tick)
				begin
					s_nxt.rxSub = s_r.rxSub + 4'h1;
					if (s_r.rxSub == SUB_MID)
					begin
						// A glitch shorter than half a bit is dropped.
						s_nxt.rxSub = 4'h0;
						s_nxt.rxState = rxLine ? RX_IDLE : RX_DATA;
					end
				end
			end
			RX_DATA:
			begin
				if (tick)
				begin
					s_nxt.rxSub = s_r.rxSub + 4'h1;
					if (s_r.rxSub == SUB_LAST)
					begin
						s_nxt.rxShift = {rxLine, s_r.rxShift[7:1]};
						s_nxt.rxPar = s_r.rxPar ^ rxLine;
						s_nxt.rxBit = s_r.rxBit + 4'h1;
						if (s_r.rxBit == lastBit)
						begin
							s_nxt.rxState = parOn ? RX_PAR : RX_STOP;
						end
					end
				end
			end
			RX_PAR:
			begin
				if (tick)
				begin
					s_nxt.rxSub = s_r.rxSub + 4'h1;
					if (s_r.rxSub == SUB_LAST)
					begin
						if (s_r.rxPar != rxLine)
						begin
							s_nxt.parErr = 1'b1;
						end
						s_nxt.rxState = RX_STOP;
					end
				end
			end
			RX_STOP:
			begin
				if (tick)
				begin
					s_nxt.rxSub = s_r.rxSub + 4'h1;
					if (s_r.rxSub == SUB_LAST)
					begin
						if (!rxLine)
						begin
							s_nxt.frmErr = 1'b1;
						end
						// A full buffer refuses the character.
						if (fifoInReady)
						begin
							pushNow = 1'b1;
						end
						else
						begin
							s_nxt.ovrErr = 1'b1;
						end
						s_nxt.rxState = RX_IDLE;
					end
				end
			end
		endcase
		// Seven-bit words land one place high in the shifter.
		pushData = s_r.cfgWord8 ? s_r.rxShift : {1'b0, s_r.rxShift[7:1]};

		// Register writes; a write to a full holding register is dropped.
		if (regWrStrobe)
		begin
			unique case (regAddr)
				REG_TXDATA:
				begin
					if (!s_r.holdFull)
					begin
						s_nxt.holdData = regWrData;
						s_nxt.holdFull = 1'b1;
					end
				end
				REG_STATUS:
				begin
					// Error flags clear on one; a new error wins over the clear unless the flag was already set.
					s_nxt.parErr = s_nxt.parErr && !(regWrData[3] && !s_r.parErr
						? 1'b0 : regWrData[3] && s_nxt.parErr == s_r.parErr);
					s_nxt.frmErr = s_nxt.frmErr && !(regWrData[4] && s_nxt.frmErr
						== s_r.frmErr);
					s_nxt.ovrErr = s_nxt.ovrErr && !(regWrData[5] && s_nxt.ovrErr
						== s_r.ovrErr);
				end
				REG_CTRL: s_nxt.forceBusy = regWrData[0];
				default: ;
			endcase
		end

		// Read data stand only in the cycle after the strobe.
		s_nxt.rdData = 8'h00;
		if (regRdStrobe)
		begin
			unique case (regAddr)
				REG_RXDATA: s_nxt.rdData = fifoOutValid ? fifoOutData : 8'h00;
				REG_STATUS: s_nxt.rdData = {hostReady, s_r.ovrErr, s_r.frmErr,
					s_r.parErr, busyNow, s_r.holdFull, fifoOutValid};
				REG_CTRL: s_nxt.rdData = {1'b0, s_r.cfgPar, s_r.cfgWord8,
					s_r.cfgBaud, s_r.cfgSoft, s_r.forceBusy};
				default: s_nxt.rdData = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; the line rests at mark from reset onward.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.txState <= TX_IDLE;
			s_r.rxState <= RX_IDLE;
			s_r.txLine <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the port's own behaviour.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_CFG_BETWEEN_FRAMES: assert property (
		!$stable(s_r.cfgBaud) |-> $past(bothIdle))
		else $error("Baud setting changed inside a frame.");

	AST_HOST_HOLD: assert property (
		(s_r.txState == TX_IDLE && !s_r.cfgSoft && hostReady)
		|=> s_r.txState == TX_IDLE)
		else $error("Transmit started while the host showed mark.");

	AST_SOFT_IGNORES_HOST: assert property (
		(s_r.txState == TX_IDLE && s_r.cfgSoft && s_r.holdFull
		&& hostReady) |=> s_r.txState == TX_START)
		else $error("Software mode waited on the host-ready input.");

	AST_BUSY_LINE: assert property (
		(!s_r.cfgSoft && busyNow) |=> printerBusy)
		else $error("Busy output not at mark while busy.");

	AST_XOFF_QUEUED: assert property (
		(s_r.cfgSoft && busyNow && !s_r.busyPrev)
		|=> s_r.xoffPend || s_r.txShift == CHAR_XOFF)
		else $error("Stop character not queued on busy.");

	AST_XON_QUEUED: assert property (
		(s_r.cfgSoft && !busyNow && s_r.busyPrev)
		|=> s_r.xonPend || s_r.txShift == CHAR_XON)
		else $error("Resume character not queued on release.");

	AST_DIV_RANGE: assert property (
		s_r.divCnt < divSel)
		else $error("Baud divider ran past its limit.");

	AST_NO_PARITY_SLOT: assert property (
		s_r.txState == TX_PAR |-> parOn)
		else $error("Parity bit sent with parity off.");

	AST_START_SPACE: assert property (
		$rose(s_r.txState == TX_START) |-> !txLine ##1 !txLine)
		else $error("Start bit not at space.");

	AST_REST_MARK: assert property (
		(s_r.txState == TX_IDLE && $past(s_r.txState) == TX_IDLE)
		|-> txLine)
		else $error("Idle line not at mark.");

endmodule

`default_nettype wire

// file: logic/spfc_pkg.sv
// Shared constants and types of the serial port with flow control.
package spfc_pkg;

	// Clock rate and baud generation at sixteen samples per bit.
	localparam int CLK_HZ = 25_000_000;
	localparam int OVERSAMPLE = 16;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam logic [9:0] DIV_2400 = 10'(CLK_HZ / (BAUD_2400 * OVERSAMPLE));
	localparam logic [9:0] DIV_4800 = 10'(CLK_HZ / (BAUD_4800 * OVERSAMPLE));
	localparam logic [9:0] DIV_9600 = 10'(CLK_HZ / (BAUD_9600 * OVERSAMPLE));
	localparam logic [9:0] DIV_19200 = 10'(CLK_HZ / (BAUD_19200 * OVERSAMPLE));
	localparam logic [3:0] SUB_MID = 4'h7;
	localparam logic [3:0] SUB_LAST = 4'hf;

	// Baud switch codes.
	localparam logic [1:0] BAUD_SEL_2400 = 2'h0;
	localparam logic [1:0] BAUD_SEL_4800 = 2'h1;
	localparam logic [1:0] BAUD_SEL_9600 = 2'h2;

	// Parity switch codes; the fourth code means no parity.
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;

	// In-band flow characters.
	localparam logic [7:0] CHAR_XOFF = 8'h13;
	localparam logic [7:0] CHAR_XON = 8'h11;

	// Register offsets on the plain register port.
	localparam logic [3:0] REG_RXDATA = 4'h0;
	localparam logic [3:0] REG_TXDATA = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_CTRL = 4'h3;

	// Receive buffer depth and the fill level that makes the port busy.
	localparam int RX_DEPTH = 8;
	localparam logic [3:0] BUSY_LEVEL = 4'h6;

	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA = 5'b00100,
		TX_PAR = 5'b01000,
		TX_STOP = 5'b10000
	} spfc_tx_t;

	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_PAR = 5'b01000,
		RX_STOP = 5'b10000
	} spfc_rx_t;

endpackage

// file: logic/spfc_fifo.sv
// Receive buffer: a small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module spfc_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH+1)-1:0] count
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [CW-1:0] fill;
	} spfc_fifo_st_t;

	spfc_fifo_st_t s_r;
	spfc_fifo_st_t s_nxt;
	logic doPush;
	logic doPop;

	////////////////////////////////////////////////////////////////////////
	// Full and empty come straight from the fill count, so they never lie.
	assign inReady = (s_r.fill != CW'(DEPTH));
	assign outValid = (s_r.fill != '0);
	assign outData = s_r.mem[s_r.rdPtr];
	assign count = s_r.fill;
	assign doPush = inValid && inReady;
	assign doPop = outValid && outReady;

	// Pointers wrap at the depth, which need not be a power of two.
	always_comb
	begin
		s_nxt = s_r;
		if (doPush)
		begin
			s_nxt.mem[s_r.wrPtr] = inData;
			s_nxt.wrPtr = (s_r.wrPtr == PW'(DEPTH-1)) ? '0 : s_r.wrPtr + 1'b1;
		end
		if (doPop)
		begin
			s_nxt.rdPtr = (s_r.rdPtr == PW'(DEPTH-1)) ? '0 : s_r.rdPtr + 1'b1;
		end
		if (doPush && !doPop)
		begin
			s_nxt.fill = s_r.fill + 1'b1;
		end
		else if (doPop && !doPush)
		begin
			s_nxt.fill = s_r.fill - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

endmodule

`default_nettype wire

// file: tb/spfc_host_model.sv
// Host side serial port model: drives the printer's receive line, decodes its transmit line.
`timescale 1ns/1ps
`default_nettype none

module spfc_host_model
	import spfc_pkg::*;
#(
	parameter int BIT_CLK = 1296
)
(
	input wire logic clock,
	input wire logic txLine,
	input wire logic printerBusy,
	input wire logic softMode,
	input wire logic word8,
	input wire logic [1:0] parity,
	output logic rxLine,
	output logic gotValid,
	output logic [7:0] gotByte
);
	logic paused = 1'b0;
	logic hasPar;

	// Parity goes out and is checked only for the even and odd codes.
	assign hasPar = (parity == PAR_EVEN) || (parity == PAR_ODD);

	function automatic logic parBit(input logic [7:0] d);
		logic [7:0] m;
		m = word8 ? d : {1'b0, d[6:0]};
		parBit = (parity == PAR_ODD) ? ~^m : ^m;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sends one frame; the host waits while told to, as a real host would.
	task automatic sendByte(input logic [7:0] d);
		while ((!softMode && printerBusy !== 1'b0) || (softMode && paused))
			@(posedge clock);
		rxLine <= 1'b0;
		repeat (BIT_CLK) @(posedge clock);
		for (int i = 0; i < (word8 ? 8 : 7); i++)
		begin
			rxLine <= d[i];
			repeat (BIT_CLK) @(posedge clock);
		end
		if (hasPar)
		begin
			rxLine <= parBit(d);
			repeat (BIT_CLK) @(posedge clock);
		end
		rxLine <= 1'b1;
		repeat (BIT_CLK) @(posedge clock);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Receiver samples mid-bit; a bad parity or stop bit poisons the byte.
	initial
	begin
		logic [7:0] b;
		logic bad;
		rxLine = 1'b1;
		gotValid = 1'b0;
		gotByte = 8'h00;
		forever
		begin
			@(posedge clock);
			gotValid <= 1'b0;
			if (txLine === 1'b0)
			begin
				repeat (BIT_CLK / 2) @(posedge clock);
				b = 8'h00;
				bad = (txLine !== 1'b0);
				for (int i = 0; i < (word8 ? 8 : 7); i++)
				begin
					repeat (BIT_CLK) @(posedge clock);
					b[i] = txLine;
				end
				if (hasPar)
				begin
					repeat (BIT_CLK) @(posedge clock);
					bad = bad | (txLine !== parBit(b));
				end
				repeat (BIT_CLK) @(posedge clock);
				bad = bad | (txLine !== 1'b1);
				if (softMode && b == CHAR_XOFF)
					paused = 1'b1;
				if (softMode && b == CHAR_XON)
					paused = 1'b0;
				gotByte <= bad ? 8'hxx : b;
				gotValid <= 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// file: tb/serial_port_flow_control_bench.sv
// Self-checking bench of the serial port: register reads and host-side characters.
`timescale 1ns/1ps
`default_nettype none

module serial_port_flow_control_bench
	import spfc_pkg::*;
;
	// One bit lasts sixteen ticks of 81 clocks at 19200 bps.
	localparam int BIT_CLK = 16 * 81;
	localparam int LIMIT = 90000;
	logic clock, rst, swFlowSoft, swWord8, rxLine, hostReady, txLine;
	logic printerBusy, regWrStrobe, regRdStrobe, gotValid, held;
	logic rdSeen = 1'b0;
	logic [1:0] swBaud, swParity;
	logic [3:0] regAddr;
	logic [7:0] regWrData, regRdData, gotByte;
	logic [7:0] regQ[$];
	logic [7:0] lineQ[$];
	int errTotal = 0;
	int testsRun = 0;
	int cycles = 0;

	spfc_top DUT(.clock(clock), .rst(rst), .swFlowSoft(swFlowSoft),
		.swBaud(swBaud), .swWord8(swWord8), .swParity(swParity),
		.rxLine(rxLine), .hostReady(hostReady), .txLine(txLine),
		.printerBusy(printerBusy), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
		.regRdData(regRdData));

	spfc_host_model #(.BIT_CLK(BIT_CLK)) host(.clock(clock), .txLine(txLine),
		.printerBusy(printerBusy), .softMode(swFlowSoft), .word8(swWord8),
		.parity(swParity), .rxLine(rxLine), .gotValid(gotValid),
		.gotByte(gotByte));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic completeRun();
		// Expected results that never turned up count against the run.
		if (lineQ.size() > 0 || regQ.size() > 0)
			errTotal++;
		$display("checks %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Strobes last one cycle; the edge after the drop is left free.
	task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge clock);
		regWrStrobe <= 1'b0;
	endtask

	task automatic regRead(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		regQ.push_back(exp);
		@(posedge clock);
		regRdStrobe <= 1'b0;
	endtask

	// Bounded wait until the host has seen every expected character.
	task automatic waitDrain();
		int n;
		n = 0;
		while (lineQ.size() > 0 && n < 20000)
		begin
			@(posedge clock);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Read data stand one cycle after the strobe, so they are taken then.
	always @(posedge clock)
	begin
		cycles++;
		if (rdSeen)
			check(regRdData, regQ.pop_front());
		if (gotValid === 1'b1 && lineQ.size() > 0)
			check(gotByte, lineQ.pop_front());
		else if (gotValid === 1'b1)
			check(8'h00, 8'hff);
		rdSeen <= regRdStrobe;
		if (cycles == LIMIT)
		begin
			errTotal++;
			completeRun();
		end
	end

	initial
	begin
		logic [7:0] d;
		void'($urandom(23318));
		rst = 1'b1;
		swFlowSoft = 1'b0;
		swBaud = 2'h3;
		swWord8 = 1'b1;
		swParity = 2'($urandom % 3);
		hostReady = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWrStrobe = 1'b0;
		regRdStrobe = 1'b0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		// Latched switches read back; unmapped and empty places read zero.
		regRead(REG_CTRL, {1'b0, swParity, 1'b1, 2'h3, 2'h0});
		regRead(4'hf, 8'h00);
		regRead(REG_RXDATA, 8'h00);
		d = 8'($urandom);
		host.sendByte(d);
		regRead(REG_STATUS, 8'h01);
		regRead(REG_RXDATA, d);
		// Forced busy shows as mark on the busy line in hardware mode.
		regWrite(REG_CTRL, 8'h01);
		repeat (2) @(posedge clock);
		check({7'h00, printerBusy}, 8'h01);
		regWrite(REG_CTRL, 8'h00);
		repeat (2) @(posedge clock);
		check({7'h00, printerBusy}, 8'h00);
		// A mark on host-ready keeps the line at rest for a whole bit.
		hostReady <= 1'b1;
		d = 8'($urandom);
		lineQ.push_back(d);
		regWrite(REG_TXDATA, d);
		held = 1'b1;
		repeat (BIT_CLK)
		begin
			@(posedge clock);
			held = held & txLine;
		end
		check({7'h00, held}, 8'h01);
		hostReady <= 1'b0;
		waitDrain();
		// Switches are taken only once both engines are idle again.
		swFlowSoft <= 1'b1;
		hostReady <= 1'b1;
		repeat (BIT_CLK) @(posedge clock);
		regRead(REG_CTRL, {1'b0, swParity, 1'b1, 2'h3, 2'h2});
		d = 8'($urandom);
		lineQ.push_back(d);
		regWrite(REG_TXDATA, d);
		waitDrain();
		lineQ.push_back(CHAR_XOFF);
		regWrite(REG_CTRL, 8'h01);
		waitDrain();
		check({7'h00, printerBusy}, 8'h00);
		lineQ.push_back(CHAR_XON);
		regWrite(REG_CTRL, 8'h00);
		waitDrain();
		repeat (4) @(posedge clock);
		completeRun();
	end
endmodule

`default_nettype wire
